// ===== core/ptb_pwm_timebase.sv
// The implementer's own choices: the register offsets and register access over APB.
`include "ptb_map.svh"

module ptb_pwm_timebase
   import ptb_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire ptb_apb_req_s apb_req,
   output ptb_apb_rsp_s apb_rsp,
   output ptb_pins_s pins,
   output logic irq
);

   // register bus
   logic [`PTB_TC_W-1:0] tcon_q, tcon_d;
   logic [7:0] period_limit_q, period_limit_d;
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] duty_write_q, duty_write_d;
   logic [6:0] deadband_count_q, deadband_count_d;
   logic [1:0] pin_direction_q, pin_direction_d;
   logic [0:0] stat_q, stat_d;
   logic [0:0] mask_q, mask_d;
   ptb_apb_rsp_s rsp_q, rsp_d;
   logic irq_q, irq_d;

   // time base and pwm core
   logic [7:0] timer_count_q, timer_count_d;
   logic [7:0] duty_active_q, duty_active_d;
   logic [1:0] duty_latch_q, duty_latch_d;
   logic [1:0] phase_q, phase_d;
   logic [3:0] pre_q, pre_d;
   logic pwm_q, pwm_d;

   ptb_pins_s pins_q, pins_d;

   logic wr_en;
   logic setup;
   logic timer_run;
   logic pwm_mode;
   logic half_mode;
   logic [1:0] pre_sel;
   logic [3:0] pre_max;
   logic icyc;
   logic inc;
   logic rollover;
   logic [1:0] tb_low;
   logic [9:0] time_base;
   logic [9:0] duty_next;
   logic [1:0] raw;
   logic [1:0] act;
   logic [6:0] db_cnt_q [2];
   logic [6:0] db_cnt_d [2];
   logic duty_match;
   logic pwm_lvl;
   logic [31:0] rd_data;
   logic rd_err;
   logic wr_tcon;
   logic wr_period;
   logic wr_timer;
   logic wr_ctrl;
   logic wr_duty;
   logic wr_active;
   logic wr_aux;
   logic wr_dir;
   logic wr_stat;
   logic wr_mask;

   assign setup = apb_req.psel & ~apb_req.penable;
   assign wr_en = apb_req.psel & apb_req.penable & rsp_q.pready & apb_req.pwrite;
   assign timer_run = tcon_q[`PTB_TC_RUN];
   assign pre_sel = tcon_q[`PTB_TC_PRE_HI:`PTB_TC_PRE_LO];
   assign pwm_mode = (ctrl_q[`PTB_CC_MODE_HI:`PTB_CC_MODE_LO] == `PTB_CC_PWM_MODE);
   assign half_mode = (ctrl_q[`PTB_CC_OMODE_HI:`PTB_CC_OMODE_LO] == PTB_OUT_HALF);

   // one write strobe per register, all qualified by the access cycle
   assign wr_tcon = wr_en & (apb_req.paddr == `PTB_OFF_TIMER_CONTROL);
   assign wr_period = wr_en & (apb_req.paddr == `PTB_OFF_PERIOD_LIMIT);
   assign wr_timer = wr_en & (apb_req.paddr == `PTB_OFF_TIMER_COUNT);
   assign wr_ctrl = wr_en & (apb_req.paddr == `PTB_OFF_CAPTURE_PWM_CONTROL);
   assign wr_duty = wr_en & (apb_req.paddr == `PTB_OFF_DUTY_WRITE);
   assign wr_active = wr_en & (apb_req.paddr == `PTB_OFF_DUTY_ACTIVE) & ~pwm_mode;
   assign wr_aux = wr_en & (apb_req.paddr == `PTB_OFF_PWM_AUX_CONTROL);
   assign wr_dir = wr_en & (apb_req.paddr == `PTB_OFF_PIN_DIRECTION);
   assign wr_stat = wr_en & (apb_req.paddr == `PTB_OFF_IRQ_STATUS);
   assign wr_mask = wr_en & (apb_req.paddr == `PTB_OFF_IRQ_MASK);

   // prescaler counts instruction cycles; the postscale bits are never read here
   always_comb begin
      unique case (pre_sel)
         `PTB_PRE_1: pre_max = `PTB_PRE_MAX_1;
         `PTB_PRE_4: pre_max = `PTB_PRE_MAX_4;
         default: pre_max = `PTB_PRE_MAX_16;
      endcase
   end

   // one timer increment per 4 clocks x prescale
   assign icyc = (phase_q == `PTB_PHASE_LAST);
   assign inc = timer_run & icyc & (pre_q == pre_max);
   assign rollover = inc & (timer_count_q == period_limit_q);

   // low time-base bits: clock phase at 1:1, prescaler bits otherwise
   always_comb begin
      if (pre_sel == `PTB_PRE_1) begin
         tb_low = phase_q;
      end else if (pre_sel == `PTB_PRE_4) begin
         tb_low = pre_q[1:0];
      end else begin
         tb_low = pre_q[3:2];
      end
   end
   assign time_base = {timer_count_q, tb_low};

   // duty value assembled from write register and control bits 5:4
   assign duty_next = {duty_write_q, ctrl_q[`PTB_CC_DLOW_HI:`PTB_CC_DLOW_LO]};

   // the match masks the level in its own cycle; a registered clear alone stretches each pulse by a clock
   assign duty_match = (time_base == {duty_active_q, duty_latch_q});
   assign pwm_lvl = pwm_q & ~duty_match;

   // read mux; the word is taken in the setup cycle and stands with pready
   always_comb begin
      rd_data = '0;
      rd_err = 1'b0;
      unique case (apb_req.paddr)
         `PTB_OFF_TIMER_CONTROL: rd_data = {25'h0000000, tcon_q};
         `PTB_OFF_PERIOD_LIMIT: rd_data = {24'h000000, period_limit_q};
         `PTB_OFF_TIMER_COUNT: rd_data = {24'h000000, timer_count_q};
         `PTB_OFF_CAPTURE_PWM_CONTROL: rd_data = {24'h000000, ctrl_q};
         `PTB_OFF_DUTY_WRITE: rd_data = {24'h000000, duty_write_q};
         `PTB_OFF_DUTY_ACTIVE: rd_data = {24'h000000, duty_active_q};
         `PTB_OFF_PWM_AUX_CONTROL: rd_data = {25'h0000000, deadband_count_q};
         `PTB_OFF_PIN_DIRECTION: rd_data = {30'h00000000, pin_direction_q};
         `PTB_OFF_IRQ_STATUS: rd_data = {31'h00000000, stat_q};
         `PTB_OFF_IRQ_MASK: rd_data = {31'h00000000, mask_q};
         default: rd_err = 1'b1;
      endcase
   end

   // answer one cycle after setup, so the access phase sees pready at once
   always_comb begin
      rsp_d = '0;
      if (setup) begin
         rsp_d.pready = 1'b1;
         rsp_d.prdata = rd_data;
         rsp_d.pslverr = rd_err;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsp_q <= '0;
      end else begin
         rsp_q <= rsp_d;
      end
   end

   // configuration registers; writes land at the access edge, at any time
   always_comb begin
      tcon_d = tcon_q;
      period_limit_d = period_limit_q;
      ctrl_d = ctrl_q;
      duty_write_d = duty_write_q;
      deadband_count_d = deadband_count_q;
      pin_direction_d = pin_direction_q;
      if (wr_tcon) begin
         tcon_d = apb_req.pwdata[`PTB_TC_W-1:0];
      end
      if (wr_period) begin
         period_limit_d = apb_req.pwdata[7:0];
      end
      if (wr_ctrl) begin
         ctrl_d = apb_req.pwdata[7:0];
      end
      if (wr_duty) begin
         duty_write_d = apb_req.pwdata[7:0];
      end
      if (wr_aux) begin
         deadband_count_d = apb_req.pwdata[6:0];
      end
      if (wr_dir) begin
         pin_direction_d = apb_req.pwdata[1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tcon_q <= '0;
         period_limit_q <= `PTB_RST_PERIOD;
         ctrl_q <= `PTB_RST_BYTE;
         duty_write_q <= `PTB_RST_BYTE;
         deadband_count_q <= '0;
         pin_direction_q <= `PTB_RST_DIR;
      end else begin
         tcon_q <= tcon_d;
         period_limit_q <= period_limit_d;
         ctrl_q <= ctrl_d;
         duty_write_q <= duty_write_d;
         deadband_count_q <= deadband_count_d;
         pin_direction_q <= pin_direction_d;
      end
   end

   // set beats the write-one clear in the same cycle
   always_comb begin
      stat_d = stat_q;
      mask_d = mask_q;
      if (wr_stat) begin
         stat_d = stat_q & ~apb_req.pwdata[0:0];
      end
      if (wr_mask) begin
         mask_d = apb_req.pwdata[0:0];
      end
      if (rollover) begin
         stat_d[`PTB_IRQ_MATCH] = 1'b1;
      end
      irq_d = |(stat_d & mask_d);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= '0;
         mask_q <= '0;
         irq_q <= 1'b0;
      end else begin
         stat_q <= stat_d;
         mask_q <= mask_d;
         irq_q <= irq_d;
      end
   end

   // clock phase and prescaler; a timer write restarts the prescaler with it
   always_comb begin
      phase_d = phase_q + 2'h1;
      pre_d = pre_q;
      if (!timer_run) begin
         pre_d = '0;
      end else if (icyc) begin
         pre_d = (pre_q == pre_max) ? 4'h0 : pre_q + 4'h1;
      end
      if (wr_timer) begin
         pre_d = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_q <= '0;
         pre_q <= '0;
      end else begin
         phase_q <= phase_d;
         pre_q <= pre_d;
      end
   end

   // timer count
   always_comb begin
      timer_count_d = timer_count_q;
      if (rollover) begin
         timer_count_d = '0;
      end else if (inc) begin
         timer_count_d = timer_count_q + 8'h01;
      end
      // software may move the timer at any time
      if (wr_timer) begin
         timer_count_d = apb_req.pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_count_q <= '0;
      end else begin
         timer_count_q <= timer_count_d;
      end
   end

   // duty buffer and pwm level
   always_comb begin
      duty_active_d = duty_active_q;
      duty_latch_d = duty_latch_q;
      pwm_d = pwm_q;
      if (rollover) begin
         duty_active_d = duty_next[9:2];
         duty_latch_d = duty_next[1:0];
      end
      // direct load only outside pwm mode
      if (wr_active) begin
         duty_active_d = apb_req.pwdata[7:0];
      end
      if (!pwm_mode) begin
         pwm_d = 1'b0;
      end else if (rollover) begin
         pwm_d = (duty_next != 10'h000);
      end else if (duty_match) begin
         pwm_d = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_active_q <= `PTB_RST_BYTE;
         duty_latch_q <= '0;
         pwm_q <= 1'b0;
      end else begin
         duty_active_q <= duty_active_d;
         duty_latch_q <= duty_latch_d;
         pwm_q <= pwm_d;
      end
   end

   // dead band: in half mode an output turns active only after its level has been asked for
   // deadband_count instruction cycles; a shorter interval never reaches it
   assign raw[0] = pwm_lvl;
   assign raw[1] = pwm_mode & ~pwm_lvl;

   for (genvar i = 0; i < 2; i++) begin : g_db
      always_comb begin
         db_cnt_d[i] = db_cnt_q[i];
         act[i] = 1'b0;
         if (!raw[i]) begin
            db_cnt_d[i] = '0;
         end else if (db_cnt_q[i] == deadband_count_q) begin
            act[i] = 1'b1;
         end else if (icyc) begin
            db_cnt_d[i] = db_cnt_q[i] + 7'h01;
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            db_cnt_q[i] <= '0;
         end else begin
            db_cnt_q[i] <= db_cnt_d[i];
         end
      end
   end

   // pins: direction bit set means tristated, as after reset
   always_comb begin
      pins_d.out_a = half_mode ? act[0] : pwm_lvl;
      pins_d.out_b = half_mode & act[1];
      pins_d.oe_a = pwm_mode & ~pin_direction_q[0];
      pins_d.oe_b = pwm_mode & half_mode & ~pin_direction_q[1];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_q <= '0;
      end else begin
         pins_q <= pins_d;
      end
   end

   assign apb_rsp = rsp_q;
   assign pins = pins_q;
   assign irq = irq_q;

endmodule // ptb_pwm_timebase

// ===== core/ptb_map.svh
`ifndef PTB_MAP_SVH
`define PTB_MAP_SVH

// register byte offsets
`define PTB_OFF_TIMER_CONTROL 8'h00
`define PTB_OFF_PERIOD_LIMIT 8'h04
`define PTB_OFF_TIMER_COUNT 8'h08
`define PTB_OFF_CAPTURE_PWM_CONTROL 8'h0C
`define PTB_OFF_DUTY_WRITE 8'h10
`define PTB_OFF_DUTY_ACTIVE 8'h14
`define PTB_OFF_PWM_AUX_CONTROL 8'h18
`define PTB_OFF_PIN_DIRECTION 8'h1C
`define PTB_OFF_IRQ_STATUS 8'h20
`define PTB_OFF_IRQ_MASK 8'h24

// timer_control fields
`define PTB_TC_RUN 0
`define PTB_TC_PRE_HI 2
`define PTB_TC_PRE_LO 1
`define PTB_TC_POST_HI 6
`define PTB_TC_POST_LO 3
`define PTB_TC_W 7

// capture_pwm_control fields
`define PTB_CC_MODE_HI 3
`define PTB_CC_MODE_LO 2
`define PTB_CC_DLOW_HI 5
`define PTB_CC_DLOW_LO 4
`define PTB_CC_OMODE_HI 7
`define PTB_CC_OMODE_LO 6
`define PTB_CC_PWM_MODE 2'h3

// prescale encodings and prescaler terminal counts
`define PTB_PRE_1 2'h0
`define PTB_PRE_4 2'h1
`define PTB_PRE_MAX_1 4'h0
`define PTB_PRE_MAX_4 4'h3
`define PTB_PRE_MAX_16 4'hF

// four oscillator phases per instruction cycle
`define PTB_PHASE_LAST 2'h3

// interrupt status bit of the timer match flag
`define PTB_IRQ_MATCH 0

// reset values
`define PTB_RST_BYTE 8'h00
`define PTB_RST_PERIOD 8'hFF
`define PTB_RST_DIR 2'h3

`endif

// ===== core/ptb_pkg.sv
package ptb_pkg;

   typedef enum logic [1:0] {
      PTB_OUT_SINGLE = 2'h0,
      PTB_OUT_HALF = 2'h2
   } ptb_outmode_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } ptb_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ptb_apb_rsp_s;

   typedef struct packed {
      logic out_a;
      logic out_b;
      logic oe_a;
      logic oe_b;
   } ptb_pins_s;

endpackage

// ===== verif/ptb_load_model.sv
module ptb_load_model
   import ptb_pkg::*;
(
   input wire ptb_pins_s pins,
   output logic pad_a,
   output logic pad_b
);
   timeunit 1ns;
   timeprecision 1ps;
   // a released pad falls to the load pull-down, so a tristated driver never looks like a pulse
   assign pad_a = pins.oe_a & pins.out_a;
   assign pad_b = pins.oe_b & pins.out_b;
endmodule // ptb_load_model

// ===== verif/ptb_pwm_timebase_props.sv
module ptb_pwm_timebase_props
   import ptb_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire ptb_apb_req_s apb_req,
   input wire ptb_apb_rsp_s apb_rsp,
   input wire ptb_pins_s pins,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic setup, wr_acc;
   assign setup = apb_req.psel & ~apb_req.penable;
   assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
   sequence s_setup;
      setup;
   endsequence
   sequence s_answer;
      apb_rsp.pready ##1 !apb_rsp.pready;
   endsequence
   AST_READY_ONE: assert property (s_setup |=> s_answer)
      else $error("no single pready after setup");
   AST_NO_STRAY: assert property (apb_rsp.pready |-> $past(setup))
      else $error("pready without setup");
   AST_ERR_ZERO: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
      else $error("error response malformed");
   AST_UPPER_ZERO: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   AST_NO_OVERLAP: assert property (!(pins.out_a && pins.out_b))
      else $error("both outputs active");
   AST_B_AFTER_A: assert property ($rose(pins.out_b) |-> !$past(pins.out_a))
      else $error("output b without dead band");
   AST_A_AFTER_B: assert property ($rose(pins.out_a) |-> !$past(pins.out_b))
      else $error("output a without dead band");
   AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr_acc) || $past(wr_acc, 2) || $past(wr_acc, 3))
      else $error("irq dropped without a write");
endmodule // ptb_pwm_timebase_props

bind ptb_pwm_timebase ptb_pwm_timebase_props props_i (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .pins(pins), .irq(irq));

// ===== verif/ptb_pwm_timebase_tb.sv
module ptb_pwm_timebase_tb
   import ptb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   ptb_apb_req_s apb_req = '0;
   ptb_apb_rsp_s apb_rsp;
   ptb_pins_s pins;
   logic irq, pad_a, pad_b;
   int err_total = 0;
   int checks_done = 0;
   int hi, per, ha, hb, n;
   always #5 pclk = ~pclk;
   ptb_pwm_timebase ptb_pwm_timebase_i (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .pins(pins), .irq(irq));
   ptb_load_model ptb_load_model_i (.pins(pins), .pad_a(pad_a), .pad_b(pad_b));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      if (err_total == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // request held until pready is sampled; no wait-state count assumed
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d,
      output logic e);
      int k;
      k = 0;
      @(posedge pclk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (apb_rsp.pready !== 1'b1 && k < 50);
      d = apb_rsp.prdata;
      e = apb_rsp.pslverr;
      if (k >= 50) chk(32'h0, 32'h1);
      apb_req <= '0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] d;
      logic e;
      xfer(1'b1, a, wd, d, e);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
      logic [31:0] d;
      logic e;
      xfer(1'b0, a, 32'h0, d, e);
      chk(d, exp);
      chk(e, experr);
   endtask
   task automatic measure();
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pad_a !== 1'b0 && n < 3000);
      do begin
         @(posedge pclk);
         n++;
      end while (pad_a !== 1'b1 && n < 3000);
      hi = 0;
      do begin
         @(posedge pclk);
         hi++;
      end while (pad_a === 1'b1 && hi < 3000);
      per = hi;
      do begin
         @(posedge pclk);
         per++;
      end while (pad_a !== 1'b1 && per < 3000);
   endtask
   task automatic count_hi(input int cyc);
      ha = 0;
      hb = 0;
      repeat (cyc) begin
         @(posedge pclk);
         ha += int'(pad_a === 1'b1);
         hb += int'(pad_b === 1'b1);
      end
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rchk(8'h04, 32'hFF, 1'b0);
      rchk(8'h1C, 32'h3, 1'b0);
      rchk(8'h0C, 32'h0, 1'b0);
      rchk(8'h28, 32'h0, 1'b1);
      wr(8'h1C, 32'h3);
      wr(8'h04, 32'h0);
      wr(8'h0C, 32'h2C);
      wr(8'h10, 32'h0);
      wr(8'h20, 32'h1);
      wr(8'h24, 32'h1);
      wr(8'h00, 32'h1);
      n = 0;
      while (irq !== 1'b1 && n < 500) begin
         @(posedge pclk);
         n++;
      end
      chk(irq, 32'h1);
      wr(8'h1C, 32'h0);
      measure();
      chk(hi, 32'h2);
      chk(per, 32'h4);
      wr(8'h14, 32'hAA);
      rchk(8'h14, 32'h0, 1'b0);
      wr(8'h04, 32'h3);
      wr(8'h10, 32'h2);
      wr(8'h0C, 32'h1C);
      wr(8'h00, 32'h7B);
      measure();
      chk(hi, 32'h24);
      chk(per, 32'h40);
      wr(8'h10, 32'h1);
      rchk(8'h14, 32'h2, 1'b0);
      measure();
      chk(hi, 32'h14);
      wr(8'h0C, 32'h0C);
      wr(8'h10, 32'h0);
      count_hi(128);
      count_hi(128);
      chk(ha, 32'h0);
      wr(8'h00, 32'h0);
      chk(irq, 32'h1);
      wr(8'h20, 32'h1);
      repeat (3) @(posedge pclk);
      chk(irq, 32'h0);
      wr(8'h24, 32'h0);
      wr(8'h08, 32'h2);
      rchk(8'h08, 32'h2, 1'b0);
      // half the period high so both switches get an interval longer than one dead band
      wr(8'h10, 32'h2);
      wr(8'h18, 32'h1);
      wr(8'h0C, 32'h8C);
      wr(8'h00, 32'h1);
      count_hi(64);
      count_hi(64);
      chk(irq, 32'h0);
      rchk(8'h20, 32'h1, 1'b0);
      chk(pins.oe_b, 32'h1);
      chk(32'(ha > 0 && hb > 0), 32'h1);
      // a dead band longer than either interval starves both switches
      wr(8'h18, 32'h7F);
      count_hi(64);
      count_hi(64);
      chk(ha + hb, 32'h0);
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      wrap_up();
   end
endmodule // ptb_pwm_timebase_tb
